// ===== logic/hvdpr_pkg.sv
package hvdpr_pkg;

    // Serial frame layout
    localparam int          FRAME_BITS   = 16;
    localparam int          CODE_W       = 12;
    localparam int          HDR_BITS     = 4;
    localparam int          RW_POS       = 3;
    localparam logic [2:0]  SEL_NOP      = 3'h0;
    localparam logic [2:0]  SEL_INPUT    = 3'h1;
    localparam logic [2:0]  SEL_CTRL     = 3'h7;

    // Reset values and control fields
    localparam logic [11:0] CTRL_RESET   = 12'h040;
    localparam logic [11:0] CODE_RESET   = 12'h000;
    localparam int          CTRL_PWR     = 2;
    localparam int          CTRL_CLAMP   = 6;

    // Register bus map, byte offsets
    localparam int          AXI_AW       = 4;
    localparam logic [3:0]  OFS_CTRL     = 4'h0;
    localparam logic [3:0]  OFS_INPUT    = 4'h4;
    localparam logic [3:0]  OFS_CONV     = 4'h8;
    localparam logic [3:0]  OFS_STATUS   = 4'hc;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Serial pins from the host
    typedef struct packed {
        logic frame_select_n;
        logic sclk;
        logic sdi;
    } hvdpr_spi_in_s;

    // Controls handed to the analog section
    typedef struct packed {
        logic [11:0] code;
        logic        range_60v;
        logic        power_up;
        logic        clamp_ground;
        logic        hiz;
    } hvdpr_analog_s;

endpackage

// ===== logic/hvdpr_top.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module hvdpr_top (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire hvdpr_pkg::hvdpr_spi_in_s spi_in,
    output logic                         sdo,
    output logic                         sdo_oe,
    input  wire logic                    load_strobe_n,
    input  wire logic                    range_select_pin,
    output hvdpr_pkg::hvdpr_analog_s     analog,
    input  wire logic [3:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [3:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    import hvdpr_pkg::*;

    logic [4:0]  pin_meta;
    logic [4:0]  pin_sync;
    logic        cs_n_s;
    logic        sclk_s;
    logic        sdi_s;
    logic        ld_n_s;
    logic        rsel_s;
    logic        cs_n_q;
    logic        sclk_q;
    logic        ld_n_q;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        ld_fall;
    logic        frame_active;
    logic [4:0]  bit_cnt;
    logic [15:0] shift;
    logic        exec;
    logic [11:0] rd_shift;
    logic [11:0] rd_value;
    logic [11:0] ctrl;
    logic [11:0] input_code;
    logic [11:0] conv_code;
    logic        range_applied;
    logic        aw_have;
    logic        w_have;
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        axi_wr_go;
    logic        ser_wr_input;
    logic        ser_wr_ctrl;
    logic        bus_wr_input;
    logic        bus_wr_ctrl;
    logic [11:0] next_input;
    logic [11:0] next_ctrl;
    logic        load_now;

    // Pins come from outside the clock domain: two flops each
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_meta <= 5'h17; // Idle levels: frame high, clock low, strobe high
            pin_sync <= 5'h17;
        end else if (ce) begin
            pin_meta <= {spi_in.frame_select_n, spi_in.sclk, load_strobe_n, spi_in.sdi, range_select_pin};
            pin_sync <= pin_meta;
        end
    end

    assign cs_n_s = pin_sync[4];
    assign sclk_s = pin_sync[3];
    assign ld_n_s = pin_sync[2];
    assign sdi_s  = pin_sync[1];
    assign rsel_s = pin_sync[0];

    // Edge history of the synchronised pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            ld_n_q <= 1'b1;
        end else if (ce) begin
            cs_n_q <= cs_n_s;
            sclk_q <= sclk_s;
            ld_n_q <= ld_n_s;
        end
    end

    assign sclk_rise = ce & sclk_s & ~sclk_q;
    assign sclk_fall = ce & ~sclk_s & sclk_q;
    assign cs_fall   = ce & ~cs_n_s & cs_n_q;
    assign ld_fall   = ce & ~ld_n_s & ld_n_q;

    // Execute point: sixteenth falling serial clock inside a live frame
    assign exec = frame_active & ~cs_n_s & sclk_fall & (bit_cnt == 5'(FRAME_BITS));

    // Frame shifter, MSB first; frame_select_n high before execute drops it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frame_active <= 1'b0;
            bit_cnt      <= 5'h00;
            shift        <= 16'h0000;
        end else if (ce) begin
            if (cs_fall) begin
                frame_active <= 1'b1;
                bit_cnt      <= 5'h00;
            end else if (cs_n_s) begin
                frame_active <= 1'b0;
            end else if (exec) begin
                frame_active <= 1'b0;
            end else if (frame_active && sclk_rise && bit_cnt < 5'(FRAME_BITS)) begin
                shift   <= {shift[14:0], sdi_s};
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // Readback source picked by register_select
    always_comb begin
        if (shift[2:0] == SEL_CTRL) begin
            rd_value = ctrl;
        end else if (shift[2:0] == SEL_INPUT) begin
            rd_value = input_code;
        end else begin
            rd_value = 12'h000;
        end
    end

    // Readback shifter, driven from the fifth rising clock to frame end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sdo      <= 1'b0;
            sdo_oe   <= 1'b0;
            rd_shift <= 12'h000;
        end else if (ce) begin
            if (cs_n_s || exec) begin
                sdo_oe <= 1'b0;
            end else if (frame_active && sclk_rise) begin
                if (bit_cnt == 5'(HDR_BITS)) begin
                    sdo_oe   <= shift[RW_POS];
                    sdo      <= rd_value[11];
                    rd_shift <= {rd_value[10:0], 1'b0};
                end else if (bit_cnt > 5'(HDR_BITS) && bit_cnt < 5'(FRAME_BITS)) begin
                    sdo      <= rd_shift[11];
                    rd_shift <= {rd_shift[10:0], 1'b0};
                end
            end
        end
    end

    // Write decode from the serial frame and from the register bus
    assign ser_wr_input = exec & ~shift[15] & (shift[14:12] == SEL_INPUT);
    assign ser_wr_ctrl  = exec & ~shift[15] & (shift[14:12] == SEL_CTRL);
    assign axi_wr_go    = aw_have & w_have & ~s_axi_bvalid;
    assign bus_wr_input = axi_wr_go & (awaddr_q == OFS_INPUT);
    assign bus_wr_ctrl  = axi_wr_go & (awaddr_q == OFS_CTRL);

    // Byte-lane merge for bus writes
    function automatic logic [11:0] merge(input logic [11:0] old, input logic [31:0] d, input logic [3:0] s);
        merge = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Serial writes win a same-cycle clash with the bus
    always_comb begin
        if (ser_wr_input) begin
            next_input = shift[11:0];
        end else begin
            next_input = merge(input_code, wdata_q, wstrb_q);
        end
        if (ser_wr_ctrl) begin
            next_ctrl = shift[11:0];
        end else begin
            next_ctrl = merge(ctrl, wdata_q, wstrb_q);
        end
    end

    // Control register; no power gating reaches the digital side
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
        end else if (ce && (ser_wr_ctrl || bus_wr_ctrl)) begin
            ctrl <= next_ctrl;
        end
    end

    // Input register, writable in any power state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            input_code <= CODE_RESET;
        end else if (ce && (ser_wr_input || bus_wr_input)) begin
            input_code <= next_input;
        end
    end

    assign load_now = (ser_wr_input || bus_wr_input) && !ld_n_s;

    // Converter register and the range it was loaded under
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conv_code     <= CODE_RESET;
            range_applied <= 1'b0;
        end else if (ce) begin
            if (load_now) begin
                conv_code     <= next_input;
                range_applied <= ~rsel_s;
            end else if (ld_fall) begin
                conv_code     <= input_code;
                range_applied <= ~rsel_s;
            end
        end
    end

    // Analog controls; power state gates only these
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            analog <= '{code: CODE_RESET, range_60v: 1'b0, power_up: CTRL_RESET[CTRL_PWR],
                        clamp_ground: ~CTRL_RESET[CTRL_PWR] & CTRL_RESET[CTRL_CLAMP],
                        hiz: ~CTRL_RESET[CTRL_PWR] & ~CTRL_RESET[CTRL_CLAMP]};
        end else if (ce) begin
            analog.code         <= conv_code;
            analog.range_60v    <= range_applied;
            analog.power_up     <= ctrl[CTRL_PWR];
            analog.clamp_ground <= ~ctrl[CTRL_PWR] & ctrl[CTRL_CLAMP];
            analog.hiz          <= ~ctrl[CTRL_PWR] & ~ctrl[CTRL_CLAMP];
        end
    end

    // Bus write channel: address and data in either order, one at a time
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            awaddr_q      <= 4'h0;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have       <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have       <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (axi_wr_go) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_q == OFS_CTRL || awaddr_q == OFS_INPUT) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Bus read channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                if (s_axi_araddr == OFS_CTRL) begin
                    s_axi_rdata <= {20'h00000, ctrl};
                end else if (s_axi_araddr == OFS_INPUT) begin
                    s_axi_rdata <= {20'h00000, input_code};
                end else if (s_axi_araddr == OFS_CONV) begin
                    s_axi_rdata <= {20'h00000, conv_code};
                end else if (s_axi_araddr == OFS_STATUS) begin
                    s_axi_rdata <= {26'h0000000, frame_active, ~ld_n_s, ~rsel_s,
                                    range_applied, ctrl[CTRL_CLAMP], ctrl[CTRL_PWR]};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ===== bench/hvdpr_checker.sv
`timescale 1ns/1ps
module hvdpr_checker
    import hvdpr_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     ce,
    input  wire hvdpr_pkg::hvdpr_spi_in_s spi_in,
    input  wire logic                     sdo_oe,
    input  wire logic                     load_strobe_n,
    input  wire hvdpr_pkg::hvdpr_analog_s analog,
    input  wire logic                     s_axi_arvalid,
    input  wire logic                     s_axi_arready,
    input  wire logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic [31:0]              s_axi_rdata
);
    int lo_age;

    // Cycles since the load strobe pin was last low; loads may only follow it
    always_ff @(posedge clk_sys) begin
        if (rst || !load_strobe_n) lo_age <= 0;
        else if (lo_age < 100) lo_age <= lo_age + 1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Reset state, power-down and output termination
    chk_reset_regs: assert property (disable iff (1'b0) rst && ce |=> analog.code == CODE_RESET && !analog.power_up)
        else $error("reset did not clear code or power");
    chk_reset_clamp: assert property (disable iff (1'b0) (rst && ce) [*2] |=> analog.clamp_ground && !analog.hiz)
        else $error("reset clamp state wrong");
    chk_power_out: assert property (analog.power_up |-> !analog.hiz && !analog.clamp_ground)
        else $error("termination active while powered");
    chk_clamp_pick: assert property (!analog.power_up |-> analog.hiz ^ analog.clamp_ground)
        else $error("power-down termination not exclusive");
    // Code and span move only with a load
    chk_code_hold: assert property ($changed(analog.code) |-> lo_age < 10)
        else $error("code changed without a load");
    chk_range_hold: assert property ($changed(analog.range_60v) |-> lo_age < 10)
        else $error("span changed without a load");
    // Serial output released outside frames
    chk_sdo_idle: assert property (spi_in.frame_select_n [*6] |-> !sdo_oe)
        else $error("sdo driven outside a frame");
    // Register reads answer and hold
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");

    cov_power: cover property ($rose(analog.power_up));
    cov_range: cover property ($changed(analog.range_60v));
    cov_read: cover property ($rose(sdo_oe));
endmodule

bind hvdpr_top hvdpr_checker u_chk (.clk_sys, .rst, .ce, .spi_in, .sdo_oe, .load_strobe_n, .analog,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ===== bench/hvdpr_host_model.sv
`timescale 1ns/1ps
module hvdpr_host_model
    import hvdpr_pkg::*;
(
    output hvdpr_pkg::hvdpr_spi_in_s spi,
    input  wire logic                sdo,
    input  wire logic                sdo_oe
);
    // Idle: frame high, link clock parked low
    initial spi = '{frame_select_n: 1'b1, sclk: 1'b0, sdi: 1'b0};

    // One frame MSB first at 48 ns per bit; fewer than 16 bits aborts it
    task automatic xfer(input logic rw, input logic [2:0] sel, input logic [11:0] dat,
                        input int nbits, output logic [11:0] rd);
        logic [15:0] w;
        w = {rw, sel, dat};
        rd = '0;
        spi.frame_select_n <= 1'b0;
        #24;
        for (int i = 15; i > 15 - nbits; i--) begin
            spi.sdi <= w[i];
            #24 spi.sclk <= 1'b1;
            #24 if (i < 12) rd[i] = sdo_oe ? sdo : 1'bx;
            spi.sclk <= 1'b0;
        end
        #24 spi.frame_select_n <= 1'b1;
        spi.sdi <= ~w[16 - nbits]; // Released line shows no stale value
        #48;
    endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
    import hvdpr_pkg::*;
    logic          clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, load_strobe_n = 1'b1, range_select_pin = 1'b1;
    hvdpr_spi_in_s spi_in;
    hvdpr_analog_s analog;
    logic          sdo, sdo_oe, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic          s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0]    s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0]   s_axi_wdata = 0, s_axi_rdata, rd;
    logic [1:0]    s_axi_bresp, s_axi_rresp, resp;
    logic [11:0]   srd;
    int            bad_count = 0, n_tests = 0, cyc = 0;

    hvdpr_top uut (.clk_sys, .rst, .ce, .spi_in, .sdo, .sdo_oe, .load_strobe_n, .range_select_pin, .analog,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    hvdpr_host_model host (.spi(spi_in), .sdo, .sdo_oe);

    // Clock and hang guard
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    task automatic results();
        if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p, w_p, aw_go, w_go;
        aw_p = 1;
        w_p = 1;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (aw_p || w_p) begin
            @(negedge clk_sys);
            aw_go = aw_p && s_axi_awready;
            w_go = w_p && s_axi_wready;
            @(posedge clk_sys);
            if (aw_go) s_axi_awvalid <= 0;
            if (w_go) s_axi_wvalid <= 0;
            aw_p = aw_p && !aw_go;
            w_p = w_p && !w_go;
        end
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask

    // Read: rready raised late so the answer must stand
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
        @(posedge clk_sys);
        s_axi_arvalid <= 0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1;
        @(posedge clk_sys);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    task automatic sx(input logic rw, input logic [2:0] sel, input logic [11:0] dat, input int n);
        host.xfer(rw, sel, dat, n, srd);
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic pins(input logic ld, input logic rng);
        load_strobe_n <= ld;
        range_select_pin <= rng;
        repeat (8) @(posedge clk_sys);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 0;
        repeat (6) @(posedge clk_sys);
        axi_rd(OFS_CTRL, rd, resp); chk(rd, 32'h40);
        axi_rd(OFS_INPUT, rd, resp); chk(rd, 32'h0);
        axi_rd(OFS_CONV, rd, resp); chk(rd, 32'h0);
        chk(32'({analog.power_up, analog.clamp_ground, analog.hiz}), 32'h2);
        sx(1, SEL_CTRL, 12'h000, 16); chk(32'(srd), 32'(CTRL_RESET));
        sx(0, SEL_INPUT, 12'h800, 16); chk(32'(analog.code), 32'h0);
        axi_rd(OFS_INPUT, rd, resp); chk(rd, 32'h800);
        pins(0, 1);
        pins(1, 1); chk(32'(analog.code), 32'h800);
        chk(32'(analog.range_60v), 32'h0);
        sx(0, SEL_CTRL, 12'h004, 16); chk(32'({analog.power_up, analog.clamp_ground, analog.hiz}), 32'h4);
        chk(32'(analog.code), 32'h800);
        sx(0, SEL_CTRL, 12'h000, 16); chk(32'({analog.power_up, analog.clamp_ground, analog.hiz}), 32'h1);
        chk(32'(analog.code), 32'h800);
        sx(1, SEL_CTRL, 12'hfff, 16); chk(32'(srd), 32'h0);
        pins(1, 0); chk(32'(analog.range_60v), 32'h0);
        pins(0, 0);
        sx(0, SEL_INPUT, 12'h123, 16); chk(32'(analog.code), 32'h123);
        chk(32'(analog.range_60v), 32'h1);
        pins(1, 0);
        sx(0, SEL_INPUT, 12'hfff, 10); axi_rd(OFS_INPUT, rd, resp); chk(rd, 32'h123);
        sx(0, 3'h2, 12'h555, 16); axi_rd(OFS_INPUT, rd, resp); chk(rd, 32'h123);
        sx(1, SEL_INPUT, 12'h000, 16); chk(32'(srd), 32'h123);
        axi_wr(OFS_CTRL, 32'h44, resp); chk(32'(resp), 32'(RESP_OKAY));
        sx(1, SEL_CTRL, 12'h000, 16); chk(32'(srd), 32'h44);
        axi_rd(OFS_STATUS, rd, resp); chk(rd, 32'h0f);
        axi_rd(4'h2, rd, resp); chk(32'(resp), 32'(RESP_SLVERR));
        axi_wr(4'h2, 32'h0, resp); chk(32'(resp), 32'(RESP_SLVERR));
        // Clock enable low: a whole frame passes unseen
        ce <= 0;
        sx(0, SEL_INPUT, 12'habc, 16);
        ce <= 1;
        repeat (4) @(posedge clk_sys);
        axi_rd(OFS_INPUT, rd, resp); chk(rd, 32'h123);
        results();
    end
endmodule
